// ### src/bank_regs_pkg.sv
// How it works
// - thirty-one physical 32-bit registers; visible set chosen by mode
// - sixteen indices visible at once; extra copies only serve exception modes
// - index 15 is the program counter, readable as any operand
// - subroutine call writes return address into current mode's index 14
// - every exception mode has private stack pointer and link copies
// - exception entry loads the new mode's link copy with return address
// - fast interrupt mode also has private copies of indices 8 to 12
// - system mode is privileged yet uses user registers without copies
// - status word holds negative, zero, carry and overflow flags
// - status word holds fast and normal interrupt mask bits
// - status word holds the compressed instruction set state bit
// - status word holds five-bit mode field selecting the register set
// - each exception mode saves the status word as before entry
// - five exception kinds, each entering its own privileged mode
// - flags update optionally; fifteen conditions test them
package bank_regs_pkg;

	localparam int WORD_W = 32;
	localparam int IDX_W = 4;
	localparam int PHYS_W = 5;
	localparam int MODE_W = 5;

	// -----------------------------------------------
	// status word fields
	// -----------------------------------------------
	localparam int BIT_NEG = 31;
	localparam int BIT_ZERO = 30;
	localparam int BIT_CARRY = 29;
	localparam int BIT_OVF = 28;
	localparam int BIT_IRQ_MASK = 7;
	localparam int BIT_FAST_MASK = 6;
	localparam int BIT_COMPACT = 5;
	localparam int FLAG_LO = 28;
	localparam int CTRL_HI = 7;

	// -----------------------------------------------
	// mode codes
	// -----------------------------------------------
	typedef enum logic [MODE_W-1:0] {
		MODE_USER = 5'h10,
		MODE_FAST = 5'h11,
		MODE_IRQ = 5'h12,
		MODE_SVC = 5'h13,
		MODE_ABORT = 5'h17,
		MODE_UNDEF = 5'h1b,
		MODE_SYSTEM = 5'h1f
	} mode_t;

	// exception kinds presented by the sequencer
	typedef enum logic [2:0] {
		EXC_FAST = 3'b000,
		EXC_IRQ = 3'b001,
		EXC_ABORT = 3'b010,
		EXC_UNDEF = 3'b011,
		EXC_TRAP = 3'b100
	} exc_t;

	// -----------------------------------------------
	// physical register layout
	// -----------------------------------------------
	localparam logic [IDX_W-1:0] IDX_FAST_LO = 4'h8;
	localparam logic [IDX_W-1:0] IDX_SP = 4'hd;
	localparam logic [IDX_W-1:0] IDX_LINK = 4'he;
	localparam logic [IDX_W-1:0] IDX_PC = 4'hf;
	localparam logic [PHYS_W-1:0] PHYS_FAST_HI_BASE = 5'h0f;
	localparam logic [PHYS_W-1:0] PHYS_BANK_BASE = 5'h12;
	localparam logic [PHYS_W-1:0] PHYS_PC = 5'h1e;

	// bank numbers: 0 user/system, 1..5 exception modes
	localparam logic [2:0] BANK_USER = 3'h0;
	localparam logic [2:0] BANK_FAST = 3'h1;
	localparam logic [2:0] BANK_IRQ = 3'h2;
	localparam logic [2:0] BANK_SVC = 3'h3;
	localparam logic [2:0] BANK_ABORT = 3'h4;
	localparam logic [2:0] BANK_UNDEF = 3'h5;

	localparam logic [WORD_W-1:0] STATUS_RESET = 32'h0000_00d3;
	localparam logic [3:0] COND_NEVER = 4'hf;

endpackage

// ### src/banked_mode_register_file.sv
`timescale 1ns/1ps
module banked_mode_register_file #(
	parameter int NUM_PHYS = 31,
	parameter int NUM_SAVED = 5
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// operand reads, answered one edge later
	input wire logic [bank_regs_pkg::IDX_W-1:0] rd_a_idx,
	input wire logic [bank_regs_pkg::IDX_W-1:0] rd_b_idx,
	output logic [bank_regs_pkg::WORD_W-1:0] rd_a_data,
	output logic [bank_regs_pkg::WORD_W-1:0] rd_b_data,
	// result write
	input wire logic wr_en,
	input wire logic [bank_regs_pkg::IDX_W-1:0] wr_idx,
	input wire logic [bank_regs_pkg::WORD_W-1:0] wr_data,
	// program counter
	input wire logic pc_wr_en,
	input wire logic [bank_regs_pkg::WORD_W-1:0] pc_wr_data,
	output logic [bank_regs_pkg::WORD_W-1:0] pc,
	// subroutine call
	input wire logic call_en,
	input wire logic [bank_regs_pkg::WORD_W-1:0] call_ret_addr,
	// condition flags
	input wire logic flag_wr_en,
	input wire logic [3:0] flag_in,
	input wire logic [3:0] cond_code,
	output logic cond_pass,
	// status word move and exception return
	input wire logic status_wr_en,
	input wire logic [bank_regs_pkg::WORD_W-1:0] status_wr_data,
	input wire logic exc_ret_en,
	// exception entry
	input wire logic exc_req,
	input wire bank_regs_pkg::exc_t exc_kind,
	input wire logic [bank_regs_pkg::WORD_W-1:0] exc_ret_addr,
	// status view
	output logic [bank_regs_pkg::WORD_W-1:0] current_status_word,
	output logic [bank_regs_pkg::WORD_W-1:0] saved_status_word,
	output logic privileged
);
	import bank_regs_pkg::*;

	typedef struct packed {
		logic [NUM_PHYS-1:0][WORD_W-1:0] gpr;
		logic [NUM_SAVED-1:0][WORD_W-1:0] saved;
		logic [WORD_W-1:0] status;
		logic [WORD_W-1:0] rd_a;
		logic [WORD_W-1:0] rd_b;
		logic [WORD_W-1:0] saved_view;
		logic cond_pass;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	// -----------------------------------------------
	// decode helpers
	// -----------------------------------------------
	function automatic logic [2:0] bank_of(input logic [MODE_W-1:0] m);
		logic [2:0] b;
		b = BANK_USER;
		case (m)
			MODE_FAST: b = BANK_FAST;
			MODE_IRQ: b = BANK_IRQ;
			MODE_SVC: b = BANK_SVC;
			MODE_ABORT: b = BANK_ABORT;
			MODE_UNDEF: b = BANK_UNDEF;
			default: b = BANK_USER;
		endcase
		return b;
	endfunction

	// architectural index to physical slot under a mode
	function automatic logic [PHYS_W-1:0] phys_of(input logic [MODE_W-1:0] m,
			input logic [IDX_W-1:0] idx);
		logic [2:0] b;
		logic [PHYS_W-1:0] p;
		b = bank_of(m);
		p = {1'b0, idx};
		if (idx == IDX_PC) begin
			p = PHYS_PC;
		end else if (idx >= IDX_SP && b != BANK_USER) begin
			// two slots per exception bank; user bank keeps slots 13 and 14
			// so it never lands on the fast bank's private 11 and 12
			p = PHYS_BANK_BASE + {b, 1'b0} + {4'h0, idx[0] ^ 1'b1};
		end else if (idx >= IDX_FAST_LO && idx < IDX_SP && b == BANK_FAST) begin
			p = PHYS_FAST_HI_BASE + {1'b0, idx - IDX_FAST_LO};
		end
		return p;
	endfunction

	// the fifteen usable conditions; the last code never passes
	function automatic logic cond_eval(input logic [3:0] c, input logic [WORD_W-1:0] st);
		logic n;
		logic z;
		logic cy;
		logic v;
		logic r;
		n = st[BIT_NEG];
		z = st[BIT_ZERO];
		cy = st[BIT_CARRY];
		v = st[BIT_OVF];
		r = 1'b0;
		case (c)
			4'h0: r = z;
			4'h1: r = !z;
			4'h2: r = cy;
			4'h3: r = !cy;
			4'h4: r = n;
			4'h5: r = !n;
			4'h6: r = v;
			4'h7: r = !v;
			4'h8: r = cy && !z;
			4'h9: r = !cy || z;
			4'ha: r = n == v;
			4'hb: r = n != v;
			4'hc: r = !z && (n == v);
			4'hd: r = z || (n != v);
			4'he: r = 1'b1;
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	function automatic logic [MODE_W-1:0] mode_of_exc(input exc_t k);
		logic [MODE_W-1:0] m;
		m = MODE_SVC;
		unique case (k)
			EXC_FAST: m = MODE_FAST;
			EXC_IRQ: m = MODE_IRQ;
			EXC_ABORT: m = MODE_ABORT;
			EXC_UNDEF: m = MODE_UNDEF;
			EXC_TRAP: m = MODE_SVC;
			default: m = MODE_SVC;
		endcase
		return m;
	endfunction

	// -----------------------------------------------
	// next state
	// -----------------------------------------------
	logic [MODE_W-1:0] cur_mode;
	logic [2:0] cur_bank;
	logic cur_priv;
	logic [MODE_W-1:0] tgt_mode;
	logic [2:0] tgt_bank;

	assign cur_mode = s_r.status[MODE_W-1:0];
	assign cur_bank = bank_of(cur_mode);
	assign cur_priv = cur_mode != MODE_USER;
	assign tgt_mode = mode_of_exc(exc_kind);
	assign tgt_bank = bank_of(tgt_mode);

	always_comb begin
		s_nxt = s_r;
		// reads see the state before this edge's writes
		s_nxt.rd_a = s_r.gpr[phys_of(cur_mode, rd_a_idx)];
		s_nxt.rd_b = s_r.gpr[phys_of(cur_mode, rd_b_idx)];
		s_nxt.cond_pass = cond_eval(cond_code, s_r.status);
		if (cur_bank == BANK_USER) begin
			s_nxt.saved_view = '0;
		end else begin
			s_nxt.saved_view = s_r.saved[cur_bank - 3'h1];
		end

		if (exc_req) begin
			// entry is atomic; other updates this edge are dropped
			s_nxt.saved[tgt_bank - 3'h1] = s_r.status;
			s_nxt.status[MODE_W-1:0] = tgt_mode;
			s_nxt.status[BIT_IRQ_MASK] = 1'b1;
			if (exc_kind == EXC_FAST) begin
				s_nxt.status[BIT_FAST_MASK] = 1'b1;
			end
			s_nxt.status[BIT_COMPACT] = 1'b0;
			s_nxt.gpr[phys_of(tgt_mode, IDX_LINK)] = exc_ret_addr;
		end else begin
			if (wr_en) begin
				s_nxt.gpr[phys_of(cur_mode, wr_idx)] = wr_data;
			end
			if (call_en) begin
				s_nxt.gpr[phys_of(cur_mode, IDX_LINK)] = call_ret_addr;
			end
			if (pc_wr_en) begin
				s_nxt.gpr[PHYS_PC] = pc_wr_data;
			end
			if (flag_wr_en) begin
				s_nxt.status[BIT_NEG:FLAG_LO] = flag_in;
			end
			if (status_wr_en) begin
				// user code may only touch the flags
				s_nxt.status[BIT_NEG:FLAG_LO] = status_wr_data[BIT_NEG:FLAG_LO];
				if (cur_priv) begin
					s_nxt.status[CTRL_HI:0] = status_wr_data[CTRL_HI:0];
				end
			end
			if (exc_ret_en && cur_bank != BANK_USER) begin
				s_nxt.status = s_r.saved[cur_bank - 3'h1];
			end
		end

		if (rst) begin
			s_nxt = '0;
			s_nxt.status = STATUS_RESET;
		end
	end

	always_ff @(posedge mclk) begin
		s_r <= s_nxt;
	end

	// -----------------------------------------------
	// outputs
	// -----------------------------------------------
	assign rd_a_data = s_r.rd_a;
	assign rd_b_data = s_r.rd_b;
	assign pc = s_r.gpr[PHYS_PC];
	assign cond_pass = s_r.cond_pass;
	assign current_status_word = s_r.status;
	assign saved_status_word = s_r.saved_view;
	assign privileged = cur_priv;

endmodule // banked_mode_register_file

// ### tb/bank_regs_assertions.sv
`timescale 1ns/1ps
module bank_regs_chk
	import bank_regs_pkg::*;
(
	// clock and strobes
	input wire logic mclk,
	input wire logic rst,
	input wire logic exc_req,
	input wire exc_t exc_kind,
	input wire logic flag_wr_en,
	input wire logic [3:0] flag_in,
	input wire logic status_wr_en,
	input wire logic exc_ret_en,
	input wire logic pc_wr_en,
	input wire logic [31:0] pc_wr_data,
	// watched outputs
	input wire logic [31:0] pc,
	input wire logic [31:0] current_status_word,
	input wire logic [31:0] saved_status_word,
	input wire logic privileged
);
	localparam mode_t MODE_OF [5] = '{MODE_FAST, MODE_IRQ, MODE_ABORT, MODE_UNDEF, MODE_SVC};
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_reset_value: assert property ($past(rst) |-> current_status_word == STATUS_RESET)
		else $error("bad status after reset");
	a_entry_mode: assert property (
		exc_req |=> current_status_word[4:0] == MODE_OF[$past(exc_kind)])
		else $error("bad entered mode");
	a_entry_masks: assert property (
		exc_req |=> current_status_word[7] && !current_status_word[5])
		else $error("bad masks on entry");
	a_fast_mask: assert property (exc_req && exc_kind == EXC_FAST |=> current_status_word[6])
		else $error("fast mask not set");
	a_entry_saves: assert property (
		exc_req ##1 !exc_req |=> saved_status_word == $past(current_status_word, 2))
		else $error("saved word wrong");
	a_priv_mode: assert property (privileged == (current_status_word[4:0] != MODE_USER))
		else $error("privilege wrong");
	a_pc_write: assert property (pc_wr_en && !exc_req |=> pc == $past(pc_wr_data))
		else $error("pc not written");
	a_flag_write: assert property (
		flag_wr_en && !exc_req && !status_wr_en && !exc_ret_en
		|=> current_status_word[31:28] == $past(flag_in))
		else $error("flags not written");
endmodule // bank_regs_chk

bind banked_mode_register_file bank_regs_chk u_chk (.mclk, .rst, .exc_req, .exc_kind,
	.flag_wr_en, .flag_in, .status_wr_en, .exc_ret_en, .pc_wr_en, .pc_wr_data, .pc,
	.current_status_word, .saved_status_word, .privileged);

// ### tb/exc_sequencer.sv
`timescale 1ns/1ps
module exc_sequencer
	import bank_regs_pkg::*;
(
	// clock and bench command
	input wire logic mclk,
	input wire logic go,
	input wire logic [2:0] kind_in,
	input wire logic [31:0] addr_in,
	// request toward the register file
	output logic exc_req,
	output exc_t exc_kind,
	output logic [31:0] exc_ret_addr
);
	initial exc_req = 1'b0;
	// address is only meaningful with the request; bit-inverted otherwise
	always @(posedge mclk) begin
		exc_req <= go;
		exc_kind <= exc_t'(kind_in);
		exc_ret_addr <= go ? addr_in : ~addr_in;
	end
endmodule // exc_sequencer

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	import bank_regs_pkg::*;
	logic mclk, rst, wr_en, pc_wr_en, call_en, flag_wr_en, status_wr_en, exc_ret_en, go;
	logic cond_pass, privileged, exc_req;
	logic [3:0] rd_a_idx, rd_b_idx, wr_idx, flag_in, cond_code;
	logic [2:0] kind_in;
	logic [31:0] rd_a_data, rd_b_data, wr_data, pc_wr_data, pc, call_ret_addr, status_wr_data;
	logic [31:0] addr_in, exc_ret_addr, current_status_word, saved_status_word;
	exc_t exc_kind;
	int bad_count, compares;
	localparam mode_t MODE_OF [5] = '{MODE_FAST, MODE_IRQ, MODE_ABORT, MODE_UNDEF, MODE_SVC};
	// pass pattern of codes 0..15 with only the zero flag set
	localparam logic [15:0] COND_EXP = 16'h66a9;
	banked_mode_register_file DUT (.mclk, .rst, .rd_a_idx, .rd_b_idx, .rd_a_data, .rd_b_data,
		.wr_en, .wr_idx, .wr_data, .pc_wr_en, .pc_wr_data, .pc, .call_en, .call_ret_addr,
		.flag_wr_en, .flag_in, .cond_code, .cond_pass, .status_wr_en, .status_wr_data,
		.exc_ret_en, .exc_req, .exc_kind, .exc_ret_addr, .current_status_word,
		.saved_status_word, .privileged);
	exc_sequencer seq (.mclk, .go, .kind_in, .addr_in, .exc_req, .exc_kind, .exc_ret_addr);
	task automatic cyc();
		@(posedge mclk);
		#1;
	endtask
	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic rd(logic [3:0] i, logic [31:0] exp);
		rd_a_idx = i;
		cyc();
		chk("read", rd_a_data, exp);
	endtask
	task automatic wr(logic [3:0] i, logic [31:0] d);
		{wr_idx, wr_data, wr_en} = {i, d, 1'b1};
		cyc();
		wr_en = 0;
	endtask
	task automatic sw(logic [31:0] d);
		{status_wr_data, status_wr_en} = {d, 1'b1};
		cyc();
		status_wr_en = 0;
	endtask
	task automatic tally_and_finish();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		mclk = 0;
		forever #2 mclk = ~mclk;
	end
	initial begin
		#100000;
		bad_count++;
		tally_and_finish();
	end
	initial begin
		{wr_en, pc_wr_en, call_en, flag_wr_en, status_wr_en, exc_ret_en, go, kind_in} = '0;
		{rd_a_idx, wr_idx, flag_in, cond_code, wr_data, pc_wr_data, call_ret_addr} = '0;
		{status_wr_data, addr_in, rd_b_idx, rst} = {64'h0, 4'hf, 1'b1};
		repeat (5) cyc();
		rst = 0;
		chk("reset", current_status_word, STATUS_RESET);
		chk("reset priv", {31'h0, privileged}, 32'h1);
		sw(32'ha000_001f);
		wr(4'h8, 32'h1111_0008);
		{call_ret_addr, call_en} = {32'h1111_000e, 1'b1};
		cyc();
		call_en = 0;
		wr(4'hd, 32'h1111_000d);
		for (int k = 0; k < 5; k++) begin
			sw(32'ha000_003f);
			{kind_in, addr_in, go} = {k[2:0], 32'h4000_0000 + k, 1'b1};
			cyc();
			go = 0;
			cyc();
			chk("entry", current_status_word, {24'ha00000, 1'b1, k == 0, 1'b0, 5'(MODE_OF[k])});
			rd(4'he, 32'h4000_0000 + k);
			chk("saved", saved_status_word, 32'ha000_003f);
			rd(4'hd, 32'h0);
			rd(4'h8, k == 0 ? 32'h0 : 32'h1111_0008);
			if (k == 0) begin
				wr(4'hc, 32'h2222_000c);
				rd(4'hc, 32'h2222_000c);
			end
		end
		sw(32'h0000_001f);
		rd(4'hd, 32'h1111_000d);
		rd(4'hc, 32'h0);
		rd(4'he, 32'h1111_000e);
		$display("test banking done");
		{pc_wr_data, pc_wr_en} = {32'h0000_1234, 1'b1};
		cyc();
		pc_wr_en = 0;
		chk("pc", pc, 32'h0000_1234);
		rd(4'hf, 32'h0000_1234);
		chk("pc b", rd_b_data, 32'h0000_1234);
		{flag_in, flag_wr_en} = {4'h4, 1'b1};
		cyc();
		flag_wr_en = 0;
		for (int c = 0; c < 16; c++) begin
			cond_code = c[3:0];
			cyc();
			chk("cond", {31'h0, cond_pass}, {31'h0, COND_EXP[c]});
		end
		sw(32'h0000_0010);
		cyc();
		sw(32'hf000_00df);
		chk("user", current_status_word, 32'hf000_0010);
		chk("user priv", {31'h0, privileged}, 32'h0);
		{kind_in, addr_in, go} = {3'h1, 32'h8000_0000, 1'b1};
		cyc();
		go = 0;
		cyc();
		exc_ret_en = 1;
		cyc();
		exc_ret_en = 0;
		chk("return", current_status_word, 32'hf000_0010);
		$display("test status done");
		rst = 1;
		cyc();
		rst = 0;
		chk("reset again", current_status_word, STATUS_RESET);
		chk("reset pc", pc, 32'h0);
		chk("reset priv again", {31'h0, privileged}, 32'h1);
		rd(4'he, 32'h0);
		$display("test reset done");
		tally_and_finish();
	end
endmodule // testbench
